// ### evt_source.sv
// stand-in for the port's transaction logic feeding event strobes
// assumes the bench raises each fire bit for exactly one clock
module evt_source
    import ustat_pkg::*;
(
    input wire logic rst_n_i,
    input wire ustat_evt_t fire_i,
    output ustat_evt_t evt_o
);
    timeunit 1ns;
    timeprecision 1ps;

    // no traffic can arise while the port is held in reset
    assign evt_o = rst_n_i ? fire_i : '0;
endmodule // evt_source

// ### test_upstream_port_status_bits.sv
// self-checking bench for the upstream port status bank
// assumes the design asserts its own rules; this file checks values at ports
module test_upstream_port_status_bits
    import ustat_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [31:0] rdata;
    logic [15:0] cmd;
    logic [15:0] stat;
    ustat_evt_t fire = '0;
    ustat_evt_t evt;
    int n_errors = 0;
    int n_tests = 0;
    int sbit [6] = '{15, 14, 13, 12, 11, 8};

    always #5 clk = ~clk;

    evt_source src_u (.rst_n_i(nrst), .fire_i(fire), .evt_o(evt));

    upstream_port_status_bits dut_u (
        .REF_CLK_I(clk),
        .NRST_I(nrst),
        .ADDR_I(addr),
        .WDATA_I(wdata),
        .WR_I(wr),
        .RD_I(rd),
        .RDATA_O(rdata),
        .EVT_I(evt),
        .COMMAND_O(cmd),
        .STATUS_O(stat)
    );

    task automatic end_sim;
        if (n_errors == 0 && n_tests > 0)
        begin
            $display("All checks passed");
        end
        else
        begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp)
        begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask

    // one cycle of events, optionally with a write in the same cycle
    task automatic step(input ustat_evt_t m, input logic w, input logic [7:0] a,
                        input logic [31:0] d);
        @(posedge clk);
        fire <= m;
        wr <= w;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        fire <= '0;
        wr <= 1'b0;
        #1;
    endtask

    task automatic rd_reg(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk("rdata", exp, rdata);
        @(posedge clk);
        #1;
        // read data stand one cycle only
        chk("rdata idle", 32'h0, rdata);
    endtask

    initial
    begin
        repeat (2000) @(posedge clk);
        n_errors++;
        end_sim;
    end

    initial
    begin
        repeat (4) @(posedge clk);
        nrst <= 1'b1;
        #1;
        chk("status", 32'h0010, {16'h0, stat});
        chk("command", 32'h0, {16'h0, cmd});
        rd_reg(8'h04, 32'h0010_0000);
        // both enables still off: parity and error messages are dropped
        step(6'h22, 1'b0, 8'h04, 32'h0);
        chk("status", 32'h0010, {16'h0, stat});
        step('0, 1'b1, 8'h08, 32'hffff_ffff);
        chk("command", 32'h0, {16'h0, cmd});
        rd_reg(8'h08, 32'h0);
        step('0, 1'b1, 8'h04, 32'h0000_ffff);
        chk("command", 32'h0547, {16'h0, cmd});
        step('0, 1'b1, 8'h04, 32'h0000_0140);
        chk("command", 32'h0140, {16'h0, cmd});
        for (int i = 0; i < 6; i++)
        begin
            step(6'(1 << i), 1'b0, 8'h04, 32'h0);
            chk("status", 32'h0010 | (32'h1 << sbit[i]), {16'h0, stat});
            step('0, 1'b1, 8'h04, 32'h0000_0140);
            chk("status", 32'h0010 | (32'h1 << sbit[i]), {16'h0, stat});
            step('0, 1'b1, 8'h04, {16'(1 << sbit[i]), 16'h0140});
            chk("status", 32'h0010, {16'h0, stat});
        end
        // every flag up at once; the fixed bits must not move
        step(6'h3f, 1'b0, 8'h04, 32'h0);
        chk("status", 32'hf910, {16'h0, stat});
        rd_reg(8'h04, 32'hf910_0140);
        // clear all while poisoned packet and sent abort arrive: both survive
        step(6'h11, 1'b1, 8'h04, 32'hf900_0140);
        chk("status", 32'h8810, {16'h0, stat});
        // read right behind the event: the new flag is already in the word
        @(posedge clk);
        fire <= 6'h08;
        @(posedge clk);
        fire <= '0;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk("rdata", 32'h9810_0140, rdata);
        @(posedge clk);
        nrst <= 1'b0;
        #1;
        chk("status", 32'h0010, {16'h0, stat});
        chk("command", 32'h0, {16'h0, cmd});
        chk("rdata", 32'h0, rdata);
        @(posedge clk);
        nrst <= 1'b1;
        rd_reg(8'h04, 32'h0010_0000);
        end_sim;
    end
endmodule // test_upstream_port_status_bits

// ### upstream_port_status_bits.sv
// upstream port command/status dword: command half-word and status half-word
// assumes event strobes come from logic on REF_CLK_I, one cycle per event,
// and a register port that never waits: read data appear one cycle after RD
//
// Our own choice: the plain strobed port.
`include "ustat_map.svh"

module upstream_port_status_bits
    import ustat_pkg::*;
#(
    parameter int ADDR_W = `USTAT_ADDR_W
)
(
    input wire logic REF_CLK_I,
    input wire logic NRST_I,
    input wire logic [ADDR_W-1:0] ADDR_I,
    input wire logic [31:0] WDATA_I,
    input wire logic WR_I,
    input wire logic RD_I,
    output logic [31:0] RDATA_O,
    input wire ustat_evt_t EVT_I,
    output logic [15:0] COMMAND_O,
    output logic [15:0] STATUS_O
);

    localparam int NF = `USTAT_NUM_FLAGS;

    logic hit;
    logic wr_hit;
    logic [15:0] cmd_q;
    logic [15:0] cmd_d;
    logic [15:0] status;
    logic [15:0] wr_stat;
    logic [31:0] rdata_q;
    logic perr_resp_en;
    logic serr_en;
    logic [NF-1:0] flag_set;
    logic [NF-1:0] flag_clr;
    logic [NF-1:0] flag;
    logic data_perr;
    logic sig_tabort;
    logic rx_tabort;
    logic rx_mabort;
    logic sig_serr;
    logic det_perr;

    // address decode; only the one dword is mapped
    assign hit = (ADDR_I == `USTAT_CMD_STAT_OFF);
    assign wr_hit = WR_I && hit;
    assign wr_stat = WDATA_I[31:16];

    // command half-word: only the implemented control bits take writes
    always_comb
    begin
        cmd_d = cmd_q;
        if (wr_hit)
        begin
            cmd_d = (WDATA_I[15:0] & `USTAT_CMD_WR_MASK) |
                    (cmd_q & ~(`USTAT_CMD_WR_MASK));
        end
    end

    always_ff @(posedge REF_CLK_I or negedge NRST_I)
    begin
        if (!NRST_I)
            cmd_q <= `USTAT_CMD_RESET;
        else
            cmd_q <= cmd_d;
    end

    assign perr_resp_en = cmd_q[`USTAT_CMD_PERR_RESP_BIT];
    assign serr_en = cmd_q[`USTAT_CMD_SERR_EN_BIT];

    // set terms for the sticky flags, in field order
    // parity is gated by the response enable, so a disabled port never flags it
    assign flag_set[0] = EVT_I.parity_err && perr_resp_en;
    assign flag_set[1] = EVT_I.cpl_abort_sent;
    assign flag_set[2] = EVT_I.rx_cpl_abort;
    assign flag_set[3] = EVT_I.rx_cpl_unsup;
    assign flag_set[4] = EVT_I.err_msg_sent && serr_en;
    assign flag_set[5] = EVT_I.poisoned_rx;

    // clear terms: a one in the written status half-word
    assign flag_clr[0] = wr_hit && wr_stat[`USTAT_STAT_DATA_PERR_BIT];
    assign flag_clr[1] = wr_hit && wr_stat[`USTAT_STAT_SIG_TABORT_BIT];
    assign flag_clr[2] = wr_hit && wr_stat[`USTAT_STAT_RX_TABORT_BIT];
    assign flag_clr[3] = wr_hit && wr_stat[`USTAT_STAT_RX_MABORT_BIT];
    assign flag_clr[4] = wr_hit && wr_stat[`USTAT_STAT_SIG_SERR_BIT];
    assign flag_clr[5] = wr_hit && wr_stat[`USTAT_STAT_DET_PERR_BIT];

    genvar gi;
    generate
        for (gi = 0; gi < NF; gi++)
        begin : g_flag
            ustat_sticky_flag u_flag
            (
                .clk_i(REF_CLK_I),
                .rst_n_i(NRST_I),
                .set_i(flag_set[gi]),
                .clr_i(flag_clr[gi]),
                .flag_o(flag[gi])
            );
        end
    endgenerate

    assign data_perr = flag[0];
    assign sig_tabort = flag[1];
    assign rx_tabort = flag[2];
    assign rx_mabort = flag[3];
    assign sig_serr = flag[4];
    assign det_perr = flag[5];

    // status half-word: fixed bits come from the constant, which holds
    // intx pending, high frequency and consecutive capable at zero
    // and the capability chain flag at one; forwarded intx never lands here
    always_comb
    begin
        status = `USTAT_STAT_FIXED;
        status[`USTAT_STAT_DATA_PERR_BIT] = data_perr;
        status[`USTAT_STAT_SIG_TABORT_BIT] = sig_tabort;
        status[`USTAT_STAT_RX_TABORT_BIT] = rx_tabort;
        status[`USTAT_STAT_RX_MABORT_BIT] = rx_mabort;
        status[`USTAT_STAT_SIG_SERR_BIT] = sig_serr;
        status[`USTAT_STAT_DET_PERR_BIT] = det_perr;
    end

    // read data: valid only in the cycle after the strobe, zero otherwise;
    // unmapped addresses read as zero rather than echoing the bus
    always_ff @(posedge REF_CLK_I or negedge NRST_I)
    begin
        if (!NRST_I)
            rdata_q <= 32'h0000_0000;
        else if (RD_I && hit)
            rdata_q <= {status, cmd_q};
        else
            rdata_q <= 32'h0000_0000;
    end

    assign RDATA_O = rdata_q;
    assign COMMAND_O = cmd_q;
    assign STATUS_O = status;

    // checks on the bank's own behaviour

    sequence s_read_dword;
        RD_I && hit;
    endsequence

    sequence s_clear_tabort_quiet;
        wr_hit && wr_stat[`USTAT_STAT_SIG_TABORT_BIT] && !EVT_I.cpl_abort_sent;
    endsequence

    sequence s_clear_tabort_busy;
        wr_hit && wr_stat[`USTAT_STAT_SIG_TABORT_BIT] && EVT_I.cpl_abort_sent;
    endsequence

    AST_INTX_ZERO: assert property (
        @(posedge REF_CLK_I) disable iff (!NRST_I)
        s_read_dword |=> RDATA_O[`USTAT_STAT_SHIFT + `USTAT_STAT_INTX_BIT] == 1'b0)
        else $error("interrupt pending flag read as one");

    AST_CAPLIST_ONE: assert property (
        @(posedge REF_CLK_I) disable iff (!NRST_I)
        s_read_dword |=> RDATA_O[`USTAT_STAT_SHIFT + `USTAT_STAT_CAPLIST_BIT] == 1'b1)
        else $error("capability chain flag read as zero");

    AST_HIGH_FREQ_ZERO: assert property (
        @(posedge REF_CLK_I) disable iff (!NRST_I)
        s_read_dword |=> !RDATA_O[`USTAT_STAT_SHIFT + `USTAT_STAT_HIGH_FREQ_BIT])
        else $error("high frequency flag read as one");

    AST_CONSEC_ZERO: assert property (
        @(posedge REF_CLK_I) disable iff (!NRST_I)
        s_read_dword |=> !RDATA_O[`USTAT_STAT_SHIFT + `USTAT_STAT_CONSEC_BIT])
        else $error("consecutive transaction flag read as one");

    AST_DATA_PERR_SET: assert property (
        @(posedge REF_CLK_I) disable iff (!NRST_I)
        EVT_I.parity_err && perr_resp_en
        |=> data_perr ##1 (data_perr || $past(flag_clr[0])))
        else $error("data parity flag not held after enabled parity error");

    AST_SIG_TABORT_SET: assert property (
        @(posedge REF_CLK_I) disable iff (!NRST_I)
        EVT_I.cpl_abort_sent |=> STATUS_O[`USTAT_STAT_SIG_TABORT_BIT])
        else $error("signaled abort flag missed");

    AST_RX_TABORT_SET: assert property (
        @(posedge REF_CLK_I) disable iff (!NRST_I)
        EVT_I.rx_cpl_abort ##1 RD_I && hit && !flag_clr[2]
        |=> RDATA_O[`USTAT_STAT_SHIFT + `USTAT_STAT_RX_TABORT_BIT])
        else $error("received abort flag not seen on read");

    AST_RX_MABORT_SET: assert property (
        @(posedge REF_CLK_I) disable iff (!NRST_I)
        EVT_I.rx_cpl_unsup |=> rx_mabort)
        else $error("master abort flag missed");

    AST_PERR_GATED: assert property (
        @(posedge REF_CLK_I) disable iff (!NRST_I)
        !perr_resp_en && !data_perr |=> !data_perr)
        else $error("data parity flag set while response disabled");

    AST_SERR_SET: assert property (
        @(posedge REF_CLK_I) disable iff (!NRST_I)
        (EVT_I.err_msg_sent && serr_en |=> sig_serr) and
        (EVT_I.err_msg_sent && !serr_en && !sig_serr |=> !sig_serr))
        else $error("system error flag does not follow the enable");

    AST_POISON_SET: assert property (
        @(posedge REF_CLK_I) disable iff (!NRST_I)
        EVT_I.poisoned_rx |=> det_perr)
        else $error("detected parity flag missed on poisoned packet");

    AST_W1C_CLEARS: assert property (
        @(posedge REF_CLK_I) disable iff (!NRST_I)
        s_clear_tabort_quiet |=> !sig_tabort)
        else $error("write of one did not clear the flag");

    AST_SET_BEATS_CLEAR: assert property (
        @(posedge REF_CLK_I) disable iff (!NRST_I)
        s_clear_tabort_busy |=> sig_tabort)
        else $error("clear won over a coincident event");

    AST_W0_KEEPS: assert property (
        @(posedge REF_CLK_I) disable iff (!NRST_I)
        wr_hit && !wr_stat[`USTAT_STAT_DET_PERR_BIT] && det_perr |=> det_perr)
        else $error("write of zero disturbed a flag");

    AST_READ_DATA: assert property (
        @(posedge REF_CLK_I) disable iff (!NRST_I)
        s_read_dword |=> RDATA_O == {$past(status), $past(cmd_q)})
        else $error("read data do not match the dword");

    AST_UNMAPPED_ZERO: assert property (
        @(posedge REF_CLK_I) disable iff (!NRST_I)
        RD_I && !hit |=> RDATA_O == 32'h0000_0000)
        else $error("unmapped read not zero");

endmodule // upstream_port_status_bits

// ### ustat_map.svh
// constants for the upstream port command/status dword: offsets, fields, resets
// assumes a 32-bit register port addressed in bytes, one word per register
// Notes on behaviour
// - legacy interrupt pending flag always reads zero
// - feature chain present flag reads one
// - high frequency capable flag reads zero
// - consecutive transaction capable flag reads zero
// - upstream parity error sets data parity flag
// - completer abort sent sets signaled abort flag
// - completer abort received sets received abort flag
// - unsupported request completion sets master abort flag
// - parity response disabled: data parity flag never set
// - error message with reporting enabled sets system flag
// - poisoned packet received sets detected parity flag
`ifndef USTAT_MAP_SVH
`define USTAT_MAP_SVH

`define USTAT_ADDR_W 8
`define USTAT_CMD_STAT_OFF 8'h04
`define USTAT_CAP_PTR_OFF 8'h34

// command half-word, low 16 bits of the dword
`define USTAT_CMD_RESET 16'h0000
`define USTAT_CMD_WR_MASK 16'h0547
`define USTAT_CMD_PERR_RESP_BIT 6
`define USTAT_CMD_SERR_EN_BIT 8

// status half-word, high 16 bits of the dword
`define USTAT_STAT_SHIFT 16
`define USTAT_STAT_INTX_BIT 3
`define USTAT_STAT_CAPLIST_BIT 4
`define USTAT_STAT_HIGH_FREQ_BIT 5
`define USTAT_STAT_CONSEC_BIT 7
`define USTAT_STAT_DATA_PERR_BIT 8
`define USTAT_STAT_SIG_TABORT_BIT 11
`define USTAT_STAT_RX_TABORT_BIT 12
`define USTAT_STAT_RX_MABORT_BIT 13
`define USTAT_STAT_SIG_SERR_BIT 14
`define USTAT_STAT_DET_PERR_BIT 15
`define USTAT_STAT_FIXED 16'h0010
`define USTAT_FLAG_RESET 1'b0
`define USTAT_NUM_FLAGS 6

`endif

// ### ustat_pkg.sv
// types shared by the upstream port status bank
// assumes the constants header is compiled alongside
package ustat_pkg;

    // one-cycle event strobes from the port's transaction logic
    typedef struct packed {
        logic parity_err;
        logic cpl_abort_sent;
        logic rx_cpl_abort;
        logic rx_cpl_unsup;
        logic err_msg_sent;
        logic poisoned_rx;
    } ustat_evt_t;

    // register port request from software
    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } ustat_req_t;

endpackage

// ### ustat_sticky_flag.sv
// one sticky error flag: hardware sets, software clears by writing one
// assumes set and clear are single-cycle strobes on the same clock
module ustat_sticky_flag
(
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic set_i,
    input wire logic clr_i,
    output logic flag_o
);

    logic flag_q;

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            flag_q <= 1'b0;
        else if (set_i)
            flag_q <= 1'b1; // set wins so a coincident event is not lost
        else if (clr_i)
            flag_q <= 1'b0;
    end

    assign flag_o = flag_q;

endmodule // ustat_sticky_flag
